// ### dps_ctrl.sv
// Digital PLL control: reference tracking, lock state, ratio and fractional-N generation
// What this block does
// - Skip enabled: reference gaps up to 20 ms keep lock.
// - After a clean reference stop, output continues for 2^23 oscillator cycles.
// - A glitch or period change counts as frequency change: unlock at once, except with skip enabled after a gap (skip reacquisition stays locked).
// - After 2^23 cycles without reference, unlock; output follows unlock enable.
// - Reference back after timeout: unlocked through acquisition, then lock.
// - Skip disabled, short gap: output runs, unlocked only while reacquiring.
// - Skip enabled, short gap: output continuous through gap and relock.
// - Three-bit setting selects minimum loop bandwidth.
// - Wide bandwidth while acquiring, selected minimum once locked.
// - User ratio is 32-bit fixed point, 12.20 or 20.12, 20.12 after reset.
// - High resolution: 12 integer bits, 20 fraction bits.
// - High multiplication: 20 integer bits, 12 fraction bits.
// - Modifier applies internally; stored user ratio stays unchanged.
// - Modifier codes map to 1,2,4,8,0.5,0.25,0.125,0.0625; reset code 000.
// - Effective ratio is user ratio times modifier, feeds fractional-N.
// - Ratio is translated against reference period to oscillator-based N.
// - Unlocked output held low unless unlock enable set.
// - Writes changing ratio, format or modifier force reacquisition.
`timescale 1ns/10ps
module dps_ctrl
    import dps_pkg::*;
#(
    parameter int GW = 24,
    parameter longint LOSS_CYCLES = LOSS_OSC_CYCLES,
    parameter longint SKIP_LIMIT = SKIP_CYCLES,
    parameter int ACQ_COUNT = ACQ_PERIODS
) (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic CE,
    input wire logic REF_IN,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic [RE_W-1:0] FRAC_N,
    output logic CLK_OUT_RUN,
    output logic LOCKED,
    output logic LOOP_BW_WIDE,
    output logic [2:0] LOOP_BW_SEL
);
    localparam logic [GW-1:0] LOSS_TC = GW'(LOSS_CYCLES - 1);
    localparam logic [GW-1:0] SKIP_TC = GW'(SKIP_LIMIT);
    localparam logic [7:0] ACQ_TC = 8'(ACQ_COUNT - 1);
    localparam logic [5:0] DIV_STEPS = 6'(RE_W);

    // ------------------------------------------------------------------
    // Avalon-MM register slave
    // ------------------------------------------------------------------
    logic ack;
    logic next_ack;
    logic [31:0] user_ratio;
    logic [31:0] next_user_ratio;
    dps_cfg_t cfg;
    dps_cfg_t next_cfg;
    logic [31:0] next_readdata;
    logic cfg_change;
    logic next_cfg_change;
    logic [5:0] idx;
    logic mapped;
    dps_state_t state;

    assign idx = AVS_ADDRESS[7:2];
    assign mapped = AVS_ADDRESS[1:0] == 2'b00;

    always_comb begin
        next_ack = 1'b0;
        next_user_ratio = user_ratio;
        next_cfg = cfg;
        next_readdata = AVS_READDATA;
        next_cfg_change = 1'b0;
        if ((AVS_READ || AVS_WRITE) && !ack) begin
            // Read data is built one cycle ahead so it comes from a flop
            next_ack = 1'b1;
            next_readdata = 32'h0000_0000;
            if (mapped && AVS_READ) begin
                unique case (idx)
                    REG_STATUS_IDX: begin
                        next_readdata[STAT_LOCK_BIT] = LOCKED;
                        next_readdata[STAT_STATE_LSB +: 3] = state;
                    end
                    REG_CONFIG_IDX: begin
                        next_readdata[CFG_SCALE_LSB +: 3] = cfg.scale_sel;
                        next_readdata[CFG_FORMAT_BIT] = cfg.format_hires;
                    end
                    REG_RATIO_IDX: next_readdata = user_ratio;
                    REG_FUNC_IDX: begin
                        next_readdata[FUNC_SKIP_BIT] = cfg.skip_en;
                        next_readdata[FUNC_OUTUNL_BIT] = cfg.out_unl_en;
                        next_readdata[FUNC_BW_LSB +: 3] = cfg.bw_sel;
                    end
                    default: next_readdata = 32'h0000_0000;
                endcase
            end
        end
        if (ack && AVS_WRITE && mapped) begin
            unique case (idx)
                REG_CONFIG_IDX: begin
                    if (AVS_BYTEENABLE[0]) begin
                        next_cfg.scale_sel = AVS_WRITEDATA[CFG_SCALE_LSB +: 3];
                        next_cfg.format_hires = AVS_WRITEDATA[CFG_FORMAT_BIT];
                    end
                end
                REG_RATIO_IDX: begin
                    for (int b = 0; b < 4; b++) begin
                        if (AVS_BYTEENABLE[b]) begin
                            next_user_ratio[8*b +: 8] = AVS_WRITEDATA[8*b +: 8];
                        end
                    end
                end
                REG_FUNC_IDX: begin
                    if (AVS_BYTEENABLE[0]) begin
                        next_cfg.skip_en = AVS_WRITEDATA[FUNC_SKIP_BIT];
                        next_cfg.out_unl_en = AVS_WRITEDATA[FUNC_OUTUNL_BIT];
                        next_cfg.bw_sel = AVS_WRITEDATA[FUNC_BW_LSB +: 3];
                    end
                end
                default: next_cfg = cfg;
            endcase
            // Only a real change of the synthesis value forces relock
            next_cfg_change = (next_user_ratio != user_ratio)
                || (next_cfg.scale_sel != cfg.scale_sel)
                || (next_cfg.format_hires != cfg.format_hires);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            ack <= 1'b0;
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h0000_0000;
            user_ratio <= RATIO_RESET;
            cfg <= '{skip_en: 1'b0, out_unl_en: 1'b0, bw_sel: BW_RESET,
                     format_hires: FORMAT_RESET, scale_sel: SCALE_RESET};
            cfg_change <= 1'b0;
        end else if (CE) begin
            ack <= next_ack;
            AVS_WAITREQUEST <= !next_ack;
            AVS_READDATA <= next_readdata;
            user_ratio <= next_user_ratio;
            cfg <= next_cfg;
            cfg_change <= next_cfg_change;
        end
    end

    // ------------------------------------------------------------------
    // Reference edge tracking
    // ------------------------------------------------------------------
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    logic [GW-1:0] gap;
    logic [GW-1:0] next_gap;
    logic [GW-1:0] period;
    logic [GW-1:0] next_period;
    logic have_period;
    logic next_have_period;
    logic ref_edge;
    logic [GW-1:0] meas;
    logic [GW-1:0] diff;
    logic period_jump;
    logic ref_missing;

    always_comb begin
        ref_edge = ref_s2 && !ref_s3;
        meas = (gap == '1) ? gap : gap + GW'(1);
        diff = (meas > period) ? meas - period : period - meas;
        // A glitch or step shows as a period far from the last one
        period_jump = ref_edge && have_period && (diff > (period >> JUMP_SHIFT));
        ref_missing = have_period && ({1'b0, gap} > {period, 1'b0});
        next_gap = ref_edge ? '0 : meas;
        next_period = ref_edge ? meas : period;
        next_have_period = have_period;
        if (ref_edge) begin
            // The edge that ends a long gap carries no valid period
            next_have_period = (state != ST_HOLD) && (state != ST_UNLOCK);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            ref_s1 <= 1'b0;
            ref_s2 <= 1'b0;
            ref_s3 <= 1'b0;
            gap <= '0;
            period <= '0;
            have_period <= 1'b0;
        end else if (CE) begin
            ref_s1 <= REF_IN;
            ref_s2 <= ref_s1;
            ref_s3 <= ref_s2;
            gap <= next_gap;
            period <= next_period;
            have_period <= next_have_period;
        end
    end

    // ------------------------------------------------------------------
    // Lock state machine
    // ------------------------------------------------------------------
    dps_state_t next_state;
    logic [7:0] acq_cnt;
    logic [7:0] next_acq_cnt;
    logic next_locked;
    logic next_run;
    logic next_bw_wide;
    logic loss_tc;

    always_comb begin
        next_state = state;
        next_acq_cnt = acq_cnt;
        loss_tc = gap >= LOSS_TC;
        unique case (state)
            ST_UNLOCK: begin
                if (ref_edge) begin
                    next_state = ST_ACQ;
                    next_acq_cnt = '0;
                end
            end
            ST_ACQ, ST_SKIPACQ: begin
                if (loss_tc) begin
                    next_state = ST_UNLOCK;
                end else if (period_jump) begin
                    next_acq_cnt = '0;
                end else if (ref_edge && have_period) begin
                    next_acq_cnt = acq_cnt + 8'h01;
                    if (acq_cnt >= ACQ_TC) begin
                        next_state = ST_LOCK;
                    end
                end
            end
            ST_LOCK: begin
                if (period_jump) begin
                    next_state = ST_ACQ;
                    next_acq_cnt = '0;
                end else if (ref_missing) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (loss_tc) begin
                    next_state = ST_UNLOCK;
                end else if (ref_edge) begin
                    // Skip mode holds lock even past the skip timeout; see the
                    // controller's duty to clear skip mode for such gaps
                    next_state = cfg.skip_en ? ST_SKIPACQ : ST_ACQ;
                    next_acq_cnt = '0;
                end
            end
            default: next_state = ST_UNLOCK;
        endcase
        if (cfg_change) begin
            next_state = ST_ACQ;
            next_acq_cnt = '0;
        end
        next_locked = (next_state == ST_LOCK) || (next_state == ST_HOLD)
            || (next_state == ST_SKIPACQ);
        next_run = next_locked || cfg.out_unl_en;
        next_bw_wide = (next_state != ST_LOCK) && (next_state != ST_HOLD);
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            state <= ST_UNLOCK;
            acq_cnt <= '0;
            LOCKED <= 1'b0;
            CLK_OUT_RUN <= 1'b0;
            LOOP_BW_WIDE <= 1'b1;
            LOOP_BW_SEL <= BW_RESET;
        end else if (CE) begin
            state <= next_state;
            acq_cnt <= next_acq_cnt;
            LOCKED <= next_locked;
            CLK_OUT_RUN <= next_run;
            LOOP_BW_WIDE <= next_bw_wide;
            LOOP_BW_SEL <= cfg.bw_sel;
        end
    end

    // ------------------------------------------------------------------
    // Fractional-N: effective ratio divided by reference period
    // ------------------------------------------------------------------
    logic [RE_W-1:0] effective_ratio;
    logic [RE_W-1:0] dividend;
    logic [RE_W-1:0] next_dividend;
    logic [GW:0] rem;
    logic [GW:0] next_rem;
    logic [GW-1:0] divisor;
    logic [GW-1:0] next_divisor;
    logic [5:0] steps;
    logic [5:0] next_steps;
    logic [RE_W-1:0] next_frac_n;
    logic [GW:0] trial;

    dps_ratio u_ratio (
        .clk(CLK_SYS),
        .reset(RESET),
        .ce(CE),
        .user_ratio(user_ratio),
        .format_hires(cfg.format_hires),
        .scale_sel(cfg.scale_sel),
        .effective_ratio(effective_ratio)
    );

    // Serial divide keeps area small; N refreshes every RE_W + 1 cycles
    always_comb begin
        next_dividend = dividend;
        next_rem = rem;
        next_divisor = divisor;
        next_steps = steps;
        next_frac_n = FRAC_N;
        trial = {rem[GW-1:0], dividend[RE_W-1]};
        if (steps == 6'h00) begin
            if (have_period && period != '0) begin
                next_dividend = effective_ratio;
                next_divisor = period;
                next_rem = '0;
                next_steps = DIV_STEPS;
            end
        end else begin
            next_dividend = {dividend[RE_W-2:0], 1'b0};
            if (trial >= {1'b0, divisor}) begin
                next_rem = trial - {1'b0, divisor};
                next_dividend[0] = 1'b1;
            end else begin
                next_rem = trial;
            end
            next_steps = steps - 6'h01;
            if (steps == 6'h01) begin
                next_frac_n = next_dividend;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            dividend <= '0;
            rem <= '0;
            divisor <= '0;
            steps <= '0;
            FRAC_N <= '0;
        end else if (CE) begin
            dividend <= next_dividend;
            rem <= next_rem;
            divisor <= next_divisor;
            steps <= next_steps;
            FRAC_N <= next_frac_n;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    write_relock_a: assert property (CE && cfg_change |=> state == ST_ACQ && !LOCKED)
        else $error("config change did not force acquisition");
    jump_unlock_a: assert property (CE && state == ST_LOCK && period_jump |=> state == ST_ACQ)
        else $error("period jump did not unlock");
    loss_unlock_a: assert property (CE && state == ST_HOLD && loss_tc && !cfg_change
        |=> state == ST_UNLOCK ##1 !LOCKED)
        else $error("loss timeout did not unlock");
    hold_locked_a: assert property (state == ST_HOLD |-> LOCKED)
        else $error("hold state reported unlocked");
    skip_return_a: assert property (CE && state == ST_HOLD && ref_edge && cfg.skip_en
        && !loss_tc && !cfg_change |=> state == ST_SKIPACQ ##1 LOCKED && CLK_OUT_RUN)
        else $error("skip return lost the output");
    noskip_return_a: assert property (CE && state == ST_HOLD && ref_edge && !cfg.skip_en
        && !loss_tc && !cfg_change |=> state == ST_ACQ ##1 !LOCKED)
        else $error("return without skip mode stayed locked");
    unlock_low_a: assert property (CE && !next_locked && !cfg.out_unl_en |=> !CLK_OUT_RUN)
        else $error("output running while unlocked");
    late_return_a: assert property (CE && state == ST_UNLOCK && ref_edge && !cfg_change
        |=> state == ST_ACQ ##1 !LOCKED)
        else $error("late return did not acquire");
    gap_restart_a: assert property (CE && ref_edge |=> gap == '0)
        else $error("loss counter not restarted on edge");
    bw_wide_a: assert property (CE && next_state == ST_ACQ |=> LOOP_BW_WIDE)
        else $error("narrow bandwidth during acquisition");
    ratio_keep_a: assert property (CE && !(ack && AVS_WRITE) |=> $stable(user_ratio))
        else $error("stored ratio altered without write");
    scale_reset_a: assert property ($rose(!RESET) |-> cfg.scale_sel == SCALE_RESET
        && !cfg.format_hires)
        else $error("format or modifier not at reset value");
endmodule // dps_ctrl

// ### dps_pkg.sv
// Shared constants, register map and types for the digital PLL ratio and skip control
package dps_pkg;
    // ------------------------------------------------------------------
    // Register indexes (byte address = 4 * index)
    // ------------------------------------------------------------------
    localparam logic [5:0] REG_STATUS_IDX = 6'h02;
    localparam logic [5:0] REG_CONFIG_IDX = 6'h03;
    localparam logic [5:0] REG_RATIO_IDX = 6'h06;
    localparam logic [5:0] REG_FUNC_IDX = 6'h16;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CFG_SCALE_LSB = 0;
    localparam int CFG_FORMAT_BIT = 3;
    localparam int FUNC_SKIP_BIT = 0;
    localparam int FUNC_OUTUNL_BIT = 1;
    localparam int FUNC_BW_LSB = 2;
    localparam int STAT_LOCK_BIT = 0;
    localparam int STAT_STATE_LSB = 1;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] RATIO_RESET = 32'h0000_0000;
    localparam logic [2:0] SCALE_RESET = 3'h0;
    localparam logic FORMAT_RESET = 1'b0;
    localparam logic [2:0] BW_RESET = 3'h0;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam longint CLK_HZ = 125_000_000;
    localparam longint SKIP_TIME_MS = 20;
    localparam longint SKIP_CYCLES = CLK_HZ * SKIP_TIME_MS / 1000;
    localparam longint LOSS_OSC_CYCLES = 64'd1 << 23;
    localparam int ACQ_PERIODS = 200;
    localparam int JUMP_SHIFT = 2;
    localparam int RE_W = 48;
    localparam int RE_FRAC = 24;

    typedef enum logic [2:0] {
        ST_UNLOCK = 3'b000,
        ST_ACQ = 3'b001,
        ST_LOCK = 3'b010,
        ST_HOLD = 3'b011,
        ST_SKIPACQ = 3'b100
    } dps_state_t;

    typedef struct packed {
        logic skip_en;
        logic out_unl_en;
        logic [2:0] bw_sel;
        logic format_hires;
        logic [2:0] scale_sel;
    } dps_cfg_t;
endpackage

// ### dps_ratio.sv
// Effective ratio: user ratio aligned to a common fixed point and scaled by the modifier
`timescale 1ns/10ps
module dps_ratio
    import dps_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [31:0] user_ratio,
    input wire logic format_hires,
    input wire logic [2:0] scale_sel,
    output logic [RE_W-1:0] effective_ratio
);
    logic [RE_W-1:0] aligned;
    logic [RE_W-1:0] next_effective_ratio;

    always_comb begin
        // Register value is only read here, never rewritten
        if (format_hires) begin
            aligned = {12'h000, user_ratio, 4'h0};
        end else begin
            aligned = {4'h0, user_ratio, 12'h000};
        end
        // Codes 0-3 multiply by 1..8, codes 4-7 divide by 2..16
        if (scale_sel[2]) begin
            // Widened sum so code 111 shifts by 4 instead of wrapping to 0
            next_effective_ratio = aligned >> ({1'b0, scale_sel[1:0]} + 3'h1);
        end else begin
            next_effective_ratio = aligned << scale_sel[1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            effective_ratio <= '0;
        end else if (ce) begin
            effective_ratio <= next_effective_ratio;
        end
    end
endmodule // dps_ratio

// ### dps_ref_src.sv
// Reference clock source model for the PLL control bench
`timescale 1ns/10ps
module dps_ref_src (
    input wire logic clk,
    input wire logic en,
    input wire logic [15:0] period,
    output logic ref_out
);
    logic [15:0] cnt;
    initial begin
        cnt = 16'h0;
        ref_out = 1'b0;
    end
    // Stops cleanly low, so a gap never looks like a glitch; one bench gap runs past the loss timeout
    always @(posedge clk) begin
        if (!en) begin
            cnt <= 16'h0;
            ref_out <= 1'b0;
        end else begin
            cnt <= (cnt + 16'h1 >= period) ? 16'h0 : cnt + 16'h1;
            ref_out <= (cnt < (period >> 1));
        end
    end
endmodule // dps_ref_src

// ### test_dps_ctrl.sv
// Self-checking bench for the PLL ratio and skip control
`timescale 1ns/10ps
module test_dps_ctrl;
    import dps_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk, rst, rd, wr, ref_in, ref_en, run, locked, bw_wide, wait_req, ce;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, q;
    logic [3:0] be;
    logic [15:0] ref_per;
    logic [47:0] frac_n;
    logic [2:0] bw_sel;
    int n_fail = 0;
    int n_checks = 0;
    // Shortened loss timeout and acquisition count keep the run brief
    dps_ctrl #(.LOSS_CYCLES(2000), .ACQ_COUNT(4)) dps_ctrl_i (
        .CLK_SYS(clk), .RESET(rst), .CE(ce), .REF_IN(ref_in),
        .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
        .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
        .FRAC_N(frac_n), .CLK_OUT_RUN(run), .LOCKED(locked),
        .LOOP_BW_WIDE(bw_wide), .LOOP_BW_SEL(bw_sel)
    );
    dps_ref_src dps_ref_src_i (.clk(clk), .en(ref_en), .period(ref_per), .ref_out(ref_in));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d);
        int n;
        @(posedge clk);
        addr <= {idx, 2'b00};
        wdata <= d;
        wr <= w;
        rd <= !w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'b0 && n < 20);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        check("bus answer", n < 20, 48'h1);
    endtask
    task automatic rd_chk(input string what, input logic [5:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        check(what, q, exp);
    endtask
    task automatic wait_lock(input logic v, input int max);
        int n;
        n = 0;
        while (locked !== v && n < max) begin
            @(posedge clk);
            n++;
        end
        check("locked", locked, v);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        check("locked", locked, 48'h0);
        check("run", run, 48'h0);
        check("bw wide", bw_wide, 48'h1);
        rd_chk("config", REG_CONFIG_IDX, 32'h0);
        rd_chk("ratio", REG_RATIO_IDX, RATIO_RESET);
        rd_chk("unmapped", 6'h3F, 32'h0);
        bus(1'b1, REG_FUNC_IDX, 32'h5 << FUNC_BW_LSB);
        rd_chk("func", REG_FUNC_IDX, 32'h14);
        check("bw sel", bw_sel, 48'h5);
        $display("test reset done");
    endtask
    task automatic t_ratio;
        logic [47:0] exp;
        bus(1'b1, REG_RATIO_IDX, 32'h0000_3000);
        wait_lock(1'b1, 2000);
        check("bw wide", bw_wide, 48'h0);
        repeat (64) @(posedge clk);
        check("frac 20.12", frac_n, 48'h18_0000);
        bus(1'b1, REG_CONFIG_IDX, 32'h8);
        bus(1'b1, REG_RATIO_IDX, 32'h0030_0000);
        for (int c = 7; c >= 0; c--) begin
            wait_lock(1'b1, 2000);
            bus(1'b1, REG_CONFIG_IDX, 32'h8 | c);
            repeat (3) @(posedge clk);
            check("relock", locked, 48'h0);
            wait_lock(1'b1, 2000);
            repeat (64) @(posedge clk);
            exp = (c < 4) ? 48'h18_0000 << c : 48'h18_0000 >> (c - 3);
            check("frac scaled", frac_n, exp);
        end
        rd_chk("ratio kept", REG_RATIO_IDX, 32'h0030_0000);
        // Only the low byte lane may land
        be <= 4'h1;
        bus(1'b1, REG_RATIO_IDX, 32'hFFFF_FF55);
        be <= 4'hF;
        rd_chk("ratio lane", REG_RATIO_IDX, 32'h0030_0055);
        wait_lock(1'b1, 2000);
        $display("test ratio done");
    endtask
    task automatic t_gaps;
        int drops;
        ref_en <= 1'b0;
        repeat (300) @(posedge clk);
        check("locked in gap", locked, 48'h1);
        check("run in gap", run, 48'h1);
        rd_chk("status hold", REG_STATUS_IDX, 32'h7);
        ref_en <= 1'b1;
        wait_lock(1'b0, 200);
        check("run unlocked", run, 48'h0);
        wait_lock(1'b1, 1000);
        bus(1'b1, REG_FUNC_IDX, 32'h15);
        drops = 0;
        ref_en <= 1'b0;
        for (int i = 0; i < 700; i++) begin
            @(posedge clk);
            if (i == 300)
                ref_en <= 1'b1;
            if (locked !== 1'b1 || run !== 1'b1)
                drops++;
        end
        check("skip drops", drops, 48'h0);
        $display("test gaps done");
    endtask
    task automatic t_loss;
        bus(1'b1, REG_FUNC_IDX, 32'h16);
        ref_en <= 1'b0;
        repeat (1500) @(posedge clk);
        check("locked before loss", locked, 48'h1);
        repeat (1500) @(posedge clk);
        check("locked after loss", locked, 48'h0);
        check("run after loss", run, 48'h1);
        check("bw after loss", bw_wide, 48'h1);
        rd_chk("status unlock", REG_STATUS_IDX, 32'h0);
        ref_en <= 1'b1;
        wait_lock(1'b1, 1000);
        ref_per <= 16'h10;
        wait_lock(1'b0, 100);
        ref_per <= 16'h20;
        wait_lock(1'b1, 1000);
        $display("test loss done");
    endtask
    task automatic t_freeze;
        // With the enable low the loss counter must not run out
        ce <= 1'b0;
        ref_en <= 1'b0;
        repeat (2500) @(posedge clk);
        check("locked frozen", locked, 48'h1);
        ce <= 1'b1;
        ref_en <= 1'b1;
        repeat (400) @(posedge clk);
        check("locked after freeze", locked, 48'h1);
        $display("test freeze done");
    endtask
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        addr = 8'h0;
        wdata = 32'h0;
        be = 4'hF;
        ce = 1'b1;
        ref_en = 1'b1;
        ref_per = 16'h20;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_ratio();
        t_gaps();
        t_loss();
        t_freeze();
        stop_test();
    end
    initial begin
        #400000;
        n_fail++;
        stop_test();
    end
endmodule // test_dps_ctrl
